//--- hdl/rec_seq_pkg.sv
package rec_seq_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_REC, ST_EOR} rec_state_t;
    typedef enum logic [1:0] {CMP_UNUSED, CMP_EQUAL, CMP_DIFFER} cmp_mode_t;
    typedef enum logic [1:0] {STOPC_NEVER, STOPC_PASS, STOPC_EQUAL, STOPC_DIFFER} stop_cond_t;
    typedef enum logic [2:0] {SAVE_NEVER = 3'd0, SAVE_EQUAL = 3'd1, SAVE_DIFFER = 3'd2, SAVE_ALWAYS = 3'd4} save_cond_t;
endpackage

//--- hdl/rec_seq_regs.svh
`ifndef REC_SEQ_REGS_SVH
`define REC_SEQ_REGS_SVH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_LIMIT 8'h08
`define REG_STATUS 8'h0C
`define REG_COUNTS 8'h10
`define REG_STAMP 8'h14
`define REG_VOLT 8'h18
`define REG_SAVE 8'h1C
`define REG_DISK 8'h20
// Control register bits (write pulses)
`define CTRL_ARM 0
`define CTRL_ADV 1
`define CTRL_STOP 2
`define CTRL_STOPX 3
`define CTRL_SETTOL 4
`define CTRL_ATOB 5
// Config register fields
`define CFG_REARM 0
`define CFG_CMP_LSB 4
`define CFG_STOPC_LSB 8
`define CFG_SAVEC_LSB 12
`define CFG_TOL_LSB 16
`define CFG_DRIVE 20
// Disk status register bits (written by firmware)
`define DISK_DONE 0
`define DISK_FULL 1
`define DISK_EXISTS 2
`define DISK_HWFAIL 3
`define DISK_OTHER_FULL 4
// Limits and reset values
`define TOL_MAX 4'h9
`define LIMIT_MAX 14'h270F
`define LIMIT_RST 14'h0001
`define PREP_CYCLES 4'h8
`define VERSION_MAX 7'h63
`endif

//--- hdl/rec_wb_regs.sv
`timescale 1ns/1ps
`include "rec_seq_regs.svh"
// Classic Wishbone slave front end: one wait state, ack lasts one cycle
module rec_wb_regs (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic cyc_i, // Bus cycle
    input wire logic stb_i, // Strobe
    input wire logic we_i, // Write enable
    input wire logic [7:0] adr_i, // Byte address
    input wire logic [3:0] sel_i, // Byte lanes
    input wire logic [31:0] dat_i, // Write data
    input wire logic [31:0] rdata_i, // Read data from core
    output logic ack_o, // Acknowledge
    output logic [31:0] dat_o, // Read data
    output logic wr_o, // Write strobe to core, one cycle
    output logic [7:0] waddr_o, // Address for core
    output logic [31:0] wdata_o // Lane-masked write data
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_t;
    wb_t q, d;
    // Answer on the cycle after the request, never twice in a row
    always_comb begin
        d = q;
        d.ack = cyc_i && stb_i && !q.ack;
        d.dat = rdata_i;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign ack_o = q.ack;
    assign dat_o = q.dat;
    // Writes take effect at the ack edge only
    assign wr_o = cyc_i && stb_i && we_i && q.ack;
    assign waddr_o = adr_i;
    assign wdata_o = {sel_i[3] ? dat_i[31:24] : 8'h00, sel_i[2] ? dat_i[23:16] : 8'h00,
                      sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};
endmodule

//--- hdl/recording_arm_sequencer.sv
`timescale 1ns/1ps
`include "rec_seq_regs.svh"
// How it works
// - Arm starts recording, busy while preparing
// - Arm during recording aborts and restarts
// - Arm clears both counters; auto rearm keeps them
// - Counters count up only at end
// - Force advance fakes advance condition
// - Plain stop leaves memory A untouched
// - Stop with transfer copies traced data
// - End raises flag, bumps counters
// - End captures date, time, voltmeter
// - Setup latched at start, copied at end
// - Data copied to A after setup
// - Auto rearm unless stop condition true
// - Auto save requested when condition holds and auto rearm is on
// - Full volume redirects save to other
// - Exists, failure, no space discard with error
// - Successful save bumps version number
// - Tolerance accepts zero through nine
// - Zero tolerance marks all must-match
// - Tolerance applied on transfer or request
// - Comparison mode zero, equal, differ
// - Stop condition never, pass, equal, differ
// - Pass limit one to 9999
module recording_arm_sequencer
    import rec_seq_pkg::*;
(
    input wire logic clk_i, // 25 MHz system clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    input wire logic we_i, // Wishbone write enable
    input wire logic [7:0] adr_i, // Wishbone byte address
    input wire logic [3:0] sel_i, // Wishbone byte selects
    input wire logic [31:0] dat_i, // Wishbone write data
    output logic ack_o, // Wishbone acknowledge
    output logic [31:0] dat_o, // Wishbone read data
    input wire logic adv_found_i, // Sequencer found its advance condition
    input wire logic trace_done_i, // Acquisition finished normally
    input wire logic mem_equal_i, // Memory A equals memory B
    input wire logic [31:0] setup_i, // Live recording setup
    input wire logic [31:0] datetime_i, // Date and time stamp
    input wire logic [15:0] volt_i, // Voltmeter reading
    output logic busy_o, // Hardware being prepared
    output logic recording_o, // Acquisition running
    output logic hw_start_o, // Start acquisition pulse
    output logic hw_abort_o, // Abort acquisition pulse
    output logic force_advance_o, // Forced advance pulse
    output logic end_of_recording_o, // End processing under way
    output logic copy_setup_o, // Copy latched setup to setup A pulse
    output logic copy_data_o, // Copy traced data to data A pulse
    output logic [31:0] setup_a_o, // Setup A store
    output logic tol_load_o, // Apply tolerance to memory B pulse
    output logic [3:0] tol_o, // Tolerance value, 0 means all must-match
    output logic save_req_o, // Auto-save request pulse
    output logic save_drive_o, // Target volume
    output logic [6:0] save_version_o, // File version for this save
    output logic save_err_o // Last save discarded
);
    typedef struct packed {
        rec_state_t st;
        logic [3:0] prep;
        logic stopx;
        logic [13:0] pass;
        logic [13:0] cmp;
        logic [31:0] setup_l;
        logic [31:0] setup_a;
        logic [31:0] stamp;
        logic [15:0] volt;
        logic rearm;
        cmp_mode_t cmp_mode;
        stop_cond_t stopc;
        save_cond_t savec;
        logic [3:0] tol;
        logic drive;
        logic [13:0] limit;
        logic [6:0] version;
        logic saving;
        logic save_err;
        logic [2:0] eor_step;
        logic busy, rec, start, abort, fadv, end_of_recording, cset, cdat, tload, sreq;
        logic [1:0] adv_s;
        logic [1:0] done_s;
        logic [1:0] eq_s;
    } st_t;
    st_t q, d;
    logic wr;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic stop_true;
    logic save_true;

    // Bus slave front end
    rec_wb_regs u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .rdata_i(rdata),
        .ack_o(ack_o),
        .dat_o(dat_o),
        .wr_o(wr),
        .waddr_o(waddr),
        .wdata_o(wdata)
    );

    // Read mux; unmapped addresses read zero
    always_comb begin
        if (adr_i == `REG_CFG) begin
            rdata = {11'h000, q.drive, q.tol, 1'b0, q.savec, 2'b00, q.stopc, 2'b00, q.cmp_mode, 3'b000, q.rearm};
        end else if (adr_i == `REG_LIMIT) begin
            rdata = {18'h0_0000, q.limit};
        end else if (adr_i == `REG_STATUS) begin
            rdata = {16'h0000, 1'b0, q.version, 2'b00, q.save_err, q.saving, q.end_of_recording, q.rec, q.busy, q.st == ST_IDLE};
        end else if (adr_i == `REG_COUNTS) begin
            rdata = {2'b00, q.cmp, 2'b00, q.pass};
        end else if (adr_i == `REG_STAMP) begin
            rdata = q.stamp;
        end else if (adr_i == `REG_VOLT) begin
            rdata = {16'h0000, q.volt};
        end else begin
            rdata = 32'h0000_0000;
        end
    end

    // Stop-rearm and save condition from the pass count and compare result
    always_comb begin
        case (q.stopc)
            STOPC_PASS: stop_true = (q.pass >= q.limit);
            STOPC_EQUAL: stop_true = q.eq_s[1];
            STOPC_DIFFER: stop_true = !q.eq_s[1];
            default: stop_true = 1'b0;
        endcase
        case (q.savec)
            SAVE_EQUAL: save_true = q.eq_s[1];
            SAVE_DIFFER: save_true = !q.eq_s[1];
            SAVE_ALWAYS: save_true = 1'b1;
            default: save_true = 1'b0;
        endcase
    end

    // Next state: commands, recording sequence, end processing, save handling
    always_comb begin
        d = q;
        // Pulses default low
        d.start = 1'b0;
        d.abort = 1'b0;
        d.fadv = 1'b0;
        d.cset = 1'b0;
        d.cdat = 1'b0;
        d.tload = 1'b0;
        d.sreq = 1'b0;
        // Pin inputs pass two flops; first stage feeds nothing else
        d.adv_s = {q.adv_s[0], adv_found_i};
        d.done_s = {q.done_s[0], trace_done_i};
        d.eq_s = {q.eq_s[0], mem_equal_i};
        // Configuration writes; illegal values refused
        if (wr && waddr == `REG_CFG) begin
            d.rearm = wdata[`CFG_REARM];
            if (wdata[`CFG_CMP_LSB +: 2] != 2'd3) begin
                d.cmp_mode = cmp_mode_t'(wdata[`CFG_CMP_LSB +: 2]);
            end
            d.stopc = stop_cond_t'(wdata[`CFG_STOPC_LSB +: 2]);
            if (wdata[`CFG_SAVEC_LSB +: 3] inside {3'd0, 3'd1, 3'd2, 3'd4}) begin
                d.savec = save_cond_t'(wdata[`CFG_SAVEC_LSB +: 3]);
            end
            if (wdata[`CFG_TOL_LSB +: 4] <= `TOL_MAX) begin
                d.tol = wdata[`CFG_TOL_LSB +: 4];
            end
            d.drive = wdata[`CFG_DRIVE];
        end
        if (wr && waddr == `REG_LIMIT && wdata[13:0] >= 14'd1 && wdata[13:0] <= `LIMIT_MAX) begin
            d.limit = wdata[13:0];
        end
        if (wr && waddr == `REG_SAVE && wdata[6:0] <= `VERSION_MAX) begin
            d.version = wdata[6:0];
        end
        // Tolerance goes to memory B only on transfer or explicit request
        if (wr && waddr == `REG_CTRL && (wdata[`CTRL_SETTOL] || wdata[`CTRL_ATOB])) begin
            d.tload = 1'b1;
        end
        // Recording controller
        case (q.st)
            ST_IDLE: begin
                d.busy = 1'b0;
            end
            ST_PREP: begin
                d.prep = q.prep - 4'h1;
                if (q.prep == 4'h1) begin
                    d.st = ST_REC;
                    d.busy = 1'b0;
                    d.rec = 1'b1;
                    d.start = 1'b1;
                end
            end
            ST_REC: begin
                if (wr && waddr == `REG_CTRL && wdata[`CTRL_ADV] && !q.adv_s[1]) begin
                    d.fadv = 1'b1;
                end
                if (wr && waddr == `REG_CTRL && wdata[`CTRL_STOPX]) begin
                    d.st = ST_EOR;
                    d.stopx = 1'b1;
                    d.abort = 1'b1;
                end else if (wr && waddr == `REG_CTRL && wdata[`CTRL_STOP]) begin
                    d.st = ST_IDLE;
                    d.rec = 1'b0;
                    d.abort = 1'b1;
                end else if (q.done_s[1]) begin
                    d.st = ST_EOR;
                    d.stopx = 1'b1;
                end
                if (d.st == ST_EOR) begin
                    d.rec = 1'b0;
                    d.end_of_recording = 1'b1;
                    d.eor_step = 3'd0;
                end
            end
            ST_EOR: begin
                d.eor_step = q.eor_step + 3'd1;
                case (q.eor_step)
                    3'd0: begin
                        // Counters count up only here, never while tracing
                        if (q.pass != `LIMIT_MAX) begin
                            d.pass = q.pass + 14'd1;
                        end
                        if ((q.cmp_mode == CMP_EQUAL && q.eq_s[1]) || (q.cmp_mode == CMP_DIFFER && !q.eq_s[1])) begin
                            d.cmp = q.cmp + 14'd1;
                        end
                        d.stamp = datetime_i;
                        d.volt = volt_i;
                    end
                    3'd1: begin
                        d.setup_a = q.setup_l;
                        d.cset = 1'b1;
                    end
                    3'd2: begin
                        d.cdat = q.stopx;
                        d.stopx = 1'b0;
                    end
                    3'd3: begin
                        if (q.rearm && q.savec != SAVE_NEVER && save_true) begin
                            d.sreq = 1'b1;
                            d.saving = 1'b1;
                            d.save_err = 1'b0;
                        end
                    end
                    default: begin
                        d.end_of_recording = 1'b0;
                        if (q.rearm && !stop_true) begin
                            d.st = ST_PREP;
                            d.busy = 1'b1;
                            d.prep = `PREP_CYCLES;
                            d.setup_l = setup_i;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                endcase
            end
            default: d.st = ST_IDLE;
        endcase
        // Firmware reports on the outstanding save
        if (q.saving && wr && waddr == `REG_DISK) begin
            if (wdata[`DISK_EXISTS] || wdata[`DISK_HWFAIL] || (wdata[`DISK_FULL] && wdata[`DISK_OTHER_FULL])) begin
                d.saving = 1'b0;
                d.save_err = 1'b1;
            end else if (wdata[`DISK_FULL]) begin
                d.drive = !q.drive;
                d.sreq = 1'b1;
            end else if (wdata[`DISK_DONE]) begin
                d.saving = 1'b0;
                d.version = (q.version == `VERSION_MAX) ? 7'h00 : q.version + 7'h01;
            end
        end
        // Arm wins in every state and restarts from scratch
        if (wr && waddr == `REG_CTRL && wdata[`CTRL_ARM]) begin
            d.abort = (q.st == ST_REC);
            d.st = ST_PREP;
            d.busy = 1'b1;
            d.rec = 1'b0;
            d.end_of_recording = 1'b0;
            d.stopx = 1'b0;
            d.prep = `PREP_CYCLES;
            d.setup_l = setup_i;
            d.pass = 14'h0000;
            d.cmp = 14'h0000;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.limit <= `LIMIT_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from state flops
    assign busy_o = q.busy;
    assign recording_o = q.rec;
    assign hw_start_o = q.start;
    assign hw_abort_o = q.abort;
    assign force_advance_o = q.fadv;
    assign end_of_recording_o = q.end_of_recording;
    assign copy_setup_o = q.cset;
    assign copy_data_o = q.cdat;
    assign setup_a_o = q.setup_a;
    assign tol_load_o = q.tload;
    assign tol_o = q.tol;
    assign save_req_o = q.sreq;
    assign save_drive_o = q.drive;
    assign save_version_o = q.version;
    assign save_err_o = q.save_err;

    // Arm always lands in preparing with counters clear
    chk_arm_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && waddr == `REG_CTRL && wdata[`CTRL_ARM]) |=> (q.st == ST_PREP && busy_o && q.pass == 14'h0000
        && q.cmp == 14'h0000)) else $error("arm did not restart");
    chk_arm_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && waddr == `REG_CTRL && wdata[`CTRL_ARM] && q.st == ST_REC) |=> hw_abort_o)
        else $error("arm during recording not aborted");
    chk_counters_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_REC) |=> (q.pass == $past(q.pass) || q.pass == 14'h0000))
        else $error("pass count moved while recording");
    chk_stop_nocopy: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_REC && wr && waddr == `REG_CTRL && wdata[`CTRL_STOP] && !wdata[`CTRL_STOPX]
        && !wdata[`CTRL_ARM]) |=> (q.st == ST_IDLE) ##1 (!copy_data_o)[*3]) else $error("plain stop copied data");
    chk_stopx_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_REC && wr && waddr == `REG_CTRL && wdata[`CTRL_STOPX] && !wdata[`CTRL_ARM])
        |=> end_of_recording_o ##3 copy_data_o) else $error("no transfer");
    chk_eor_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_EOR) |-> end_of_recording_o) else $error("end flag missing");
    chk_tol_range: assert property (@(posedge clk_i) disable iff (rst_i)
        tol_o <= `TOL_MAX) else $error("tolerance above nine");
    chk_limit_range: assert property (@(posedge clk_i) disable iff (rst_i)
        q.limit >= 14'd1 && q.limit <= `LIMIT_MAX) else $error("pass limit out of range");
    chk_tol_load: assert property (@(posedge clk_i) disable iff (rst_i)
        tol_load_o |-> $past(wr && waddr == `REG_CTRL && (wdata[`CTRL_SETTOL] || wdata[`CTRL_ATOB])))
        else $error("tolerance applied without cause");
    chk_stop_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_IDLE && !(wr && waddr == `REG_CTRL && wdata[`CTRL_ARM])) |=> q.st == ST_IDLE)
        else $error("idle left without arm");
endmodule

//--- tb/acq_far_model.sv
`timescale 1ns/1ps
// Acquisition stand-in: ends a trace run_len_i cycles after its start
module acq_far_model (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic hw_start_i, // Start pulse
    input wire logic hw_abort_i, // Abort pulse
    input wire logic [7:0] run_len_i, // Trace length, zero never ends
    output logic trace_done_o, // Trace finished
    output logic adv_found_o // Advance condition found
);
    logic [7:0] left_q; // Cycles left in the trace
    logic [1:0] hold_q; // Done hold, long enough for a two-flop synchroniser
    // Count a live trace down, then hold done for three cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || hw_abort_i) begin
            left_q <= 8'h00;
            hold_q <= 2'h0;
        end else if (hw_start_i) begin
            left_q <= run_len_i;
        end else if (left_q == 8'h01) begin
            left_q <= 8'h00;
            hold_q <= 2'h3;
        end else begin
            left_q <= (left_q == 8'h00) ? 8'h00 : left_q - 8'h01;
            hold_q <= (hold_q == 2'h0) ? 2'h0 : hold_q - 2'h1;
        end
    end
    assign trace_done_o = (hold_q != 2'h0);
    // Never found, so any forced advance stays visible
    assign adv_found_o = 1'b0;
endmodule

//--- tb/tb_recording_arm_sequencer.sv
`timescale 1ns/1ps
`include "rec_seq_regs.svh"
// Bench: bus tasks, pulse counters and an integer expectation model
module tb_recording_arm_sequencer;
    logic clk_i = 1'b0, rst_i = 1'b1; // Clock, reset
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, mem_equal_i = 1'b0; // Bus controls, compare
    logic [7:0] adr_i = 8'h00, run_len = 8'h00; // Address, trace length
    logic [3:0] sel_i = 4'hF; // All lanes
    logic [31:0] dat_i = 32'h0000_0000, setup_i = 32'h0000_0000, datetime_i = 32'h0000_0000; // Data in
    logic [15:0] volt_i = 16'h0000; // Voltmeter
    logic ack_o, busy_o, recording_o, hw_start_o, hw_abort_o, force_advance_o, end_of_recording_o;
    logic copy_setup_o, copy_data_o, tol_load_o, save_req_o, save_drive_o, save_err_o, adv_found_i, trace_done_i;
    logic [31:0] dat_o, setup_a_o, rs = 32'h0000_0006; // Read data, setup A, xorshift state
    logic [3:0] tol_o; // Applied tolerance
    logic [6:0] save_version_o; // Save version
    logic [7:0] ev; // Events counted each cycle
    int failures = 0, tests_run = 0; // Verdict counters
    int cnt[8] = '{default: 0}, snap[8]; // Event counts, snapshot
    recording_arm_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o), .adv_found_i(adv_found_i),
        .trace_done_i(trace_done_i), .mem_equal_i(mem_equal_i), .setup_i(setup_i), .datetime_i(datetime_i),
        .volt_i(volt_i), .busy_o(busy_o), .recording_o(recording_o), .hw_start_o(hw_start_o),
        .hw_abort_o(hw_abort_o), .force_advance_o(force_advance_o), .end_of_recording_o(end_of_recording_o),
        .copy_setup_o(copy_setup_o), .copy_data_o(copy_data_o), .setup_a_o(setup_a_o), .tol_load_o(tol_load_o),
        .tol_o(tol_o), .save_req_o(save_req_o), .save_drive_o(save_drive_o), .save_version_o(save_version_o),
        .save_err_o(save_err_o));
    acq_far_model far (.clk_i(clk_i), .rst_i(rst_i), .hw_start_i(hw_start_o), .hw_abort_i(hw_abort_o),
        .run_len_i(run_len), .trace_done_o(trace_done_i), .adv_found_o(adv_found_i));
    assign ev = {end_of_recording_o, save_req_o, tol_load_o, copy_data_o, copy_setup_o, force_advance_o,
        hw_abort_o, hw_start_o};
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Pulses counted per cycle; end processing counted as cycles high
    always @(negedge clk_i) begin
        for (int k = 0; k < 8; k++) begin
            if (ev[k] === 1'b1) begin
                cnt[k] <= cnt[k] + 1;
            end
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic hang(input string what);
        failures++;
        $display("unexpected timeout waiting for %s", what);
        summarize();
    endtask
    // Classic cycle: request held until ack is sampled high at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) hang("ack");
        q = dat_o;
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0000_0000, q);
    endtask
    // Polls a status bit; a slow design cannot hang the run
    task automatic wait_stat(input int b);
        logic [31:0] s;
        s = 32'h0000_0000;
        for (int n = 0; n < 600 && s[b] !== 1'b1; n++) rd(`REG_STATUS, s);
        if (s[b] !== 1'b1) hang("status");
    endtask
    task automatic wait_cnt(input int k, input int target);
        for (int n = 0; n < 3000 && cnt[k] < target; n++) @(posedge clk_i);
        if (cnt[k] < target) hang("event");
    endtask
    function automatic int delta(input int k);
        return cnt[k] - snap[k];
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] cfg(input int rearm, input int cm, input int sc, input int sv, input int tol);
        return 32'(rearm + (cm << 4) + (sc << 8) + (sv << 12) + (tol << 16));
    endfunction
    // New random setup, stamp and voltmeter values
    task automatic stir();
        rs = xs(rs);
        setup_i <= rs;
        datetime_i <= {rs[15:0], rs[31:16]};
        volt_i <= rs[23:8];
    endtask
    initial begin
        logic [31:0] r, lat;
        logic meq;
        int cm, passes, ver;
        int tols[4] = '{5, 10, 0, 9};
        int lims[3] = '{0, 10000, 9999};
        int reps[5] = '{1, 4, 8, 18, 1};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`REG_STATUS, r);
        check("status", r, 32'h0000_0001);
        foreach (lims[i]) begin
            wr(`REG_LIMIT, 32'(lims[i]));
            rd(`REG_LIMIT, r);
            check("limit", r, (lims[i] == 9999) ? 32'h0000_270F : 32'h0000_0001);
        end
        // Tolerance waits for a load; out-of-range values are refused
        ver = 0;
        for (int i = 0; i < 4; i++) begin
            snap = cnt;
            wr(`REG_CFG, cfg(0, 0, 0, 0, tols[i]));
            @(posedge clk_i);
            check("tol_held", delta(5), 0);
            wr(`REG_CTRL, (i % 2 == 0) ? 32'h0000_0010 : 32'h0000_0020);
            wait_cnt(5, snap[5] + 1);
            @(posedge clk_i);
            ver = (tols[i] <= 9) ? tols[i] : ver;
            check("tol", tol_o, 32'(ver));
        end
        // Manual arm, forced advance, plain stop, then both keys while idle
        snap = cnt;
        stir();
        wr(`REG_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        check("busy", busy_o, 1);
        wait_stat(2);
        check("starts", delta(0), 1);
        wr(`REG_CTRL, 32'h0000_0002);
        wr(`REG_CTRL, 32'h0000_0004);
        wait_stat(0);
        wr(`REG_CTRL, 32'h0000_0006);
        rd(`REG_COUNTS, r);
        check("advance", delta(2), 1);
        check("abort", delta(1), 1);
        check("no_copy", delta(4) + delta(7), 0);
        // Re-arm mid-recording, then stop with transfer
        snap = cnt;
        wr(`REG_CTRL, 32'h0000_0001);
        wait_stat(2);
        stir();
        lat = rs;
        wr(`REG_CTRL, 32'h0000_0001);
        wait_stat(2);
        check("rearm_abort", delta(1), 1);
        check("rearm_start", delta(0), 2);
        stir();
        wr(`REG_CTRL, 32'h0000_0008);
        wait_stat(0);
        check("copies", delta(3) + (delta(4) << 4), 32'h0000_0011);
        check("eor", delta(7) > 0, 1);
        check("setup_a", setup_a_o, lat);
        rd(`REG_COUNTS, r);
        check("counts", r, 32'h0000_0001);
        rd(`REG_STAMP, r);
        check("stamp", r, datetime_i);
        rd(`REG_VOLT, r);
        check("volt", r, {16'h0000, volt_i});
        // Auto re-arm under each stop condition; limit two
        run_len <= 8'h14;
        for (int sc = 0; sc < 4; sc++) begin
            stir();
            cm = (sc == 0) ? 0 : (sc == 1) ? 1 + int'(rs[0]) : sc - 1;
            meq = (sc == 2) || (sc == 1 && rs[1]);
            mem_equal_i <= meq;
            passes = ((cm == 1 && meq) || (cm == 2 && !meq)) ? 1 : 0;
            wr(`REG_LIMIT, 32'h0000_0002);
            wr(`REG_CFG, cfg(1, cm, sc, 0, 0));
            snap = cnt;
            wr(`REG_CTRL, 32'h0000_0001);
            rd(`REG_COUNTS, r);
            check("cleared", r, 0);
            wait_cnt(0, snap[0] + ((sc < 2) ? 2 : 1));
            if (sc == 1) begin
                rd(`REG_COUNTS, r);
                check("mid_counts", r, 32'(1 + (passes << 16)));
            end
            if (sc == 0) begin
                wait_stat(2);
                wr(`REG_CTRL, 32'h0000_0004);
            end
            wait_stat(0);
            if (sc != 0) begin
                rd(`REG_COUNTS, r);
                cm = (sc == 1) ? 2 : 1;
                check("counts", r, 32'(cm + ((passes * cm) << 16)));
                check("runs", delta(0), cm);
            end
        end
        // Saves: done, redirect then clash, two discards, version wrap
        mem_equal_i <= 1'b1;
        wr(`REG_LIMIT, 32'h0000_0001);
        wr(`REG_SAVE, 32'h0000_0062);
        wr(`REG_CFG, cfg(1, 1, 1, 4, 0));
        ver = 98;
        foreach (reps[i]) begin
            snap = cnt;
            wr(`REG_CTRL, 32'h0000_0001);
            wait_cnt(6, snap[6] + 1);
            if (i == 1) begin
                wr(`REG_DISK, 32'h0000_0002);
                wait_cnt(6, snap[6] + 2);
                check("drive", save_drive_o, 1);
            end
            wr(`REG_DISK, 32'(reps[i]));
            wait_stat(0);
            ver = (reps[i] != 1) ? ver : (ver == 99) ? 0 : ver + 1;
            check("version", save_version_o, 32'(ver));
            check("save_err", save_err_o, 32'(reps[i] != 1));
        end
        // Save on equal memories is skipped when they differ
        mem_equal_i <= 1'b0;
        wr(`REG_CFG, cfg(1, 1, 1, 1, 0));
        snap = cnt;
        wr(`REG_CTRL, 32'h0000_0001);
        wait_cnt(7, snap[7] + 1);
        wait_stat(0);
        check("no_save", delta(6), 0);
        summarize();
    end
endmodule
